// *** design/bstc_ctl.sv ***
// Purpose: bus service request, trigger mode and output terminator control
// Assumes: bus events arrive decoded as one-cycle pulses synchronous to clk
// Notes: scan engine lives outside; this block issues start, stop and step pulses
`timescale 1ns/1ps
`default_nettype none
module bstc_ctl
(
	// clock and reset
	input  wire logic                  clk,
	input  wire logic                  sys_rst,
	// decoded bus commands
	input  wire logic                  mask_wr,
	input  wire logic [7:0]            mask_data,
	input  wire logic                  trig_mode_wr,
	input  wire logic [2:0]            trig_mode_data,
	input  wire logic                  term_wr,
	input  wire logic [7:0]            term_chr,
	input  wire logic                  dev_clr,
	input  wire logic                  talk_addr,
	input  wire logic                  data_req,
	input  wire logic                  group_trig,
	input  wire logic                  exec_chr,
	input  wire logic                  spoll_rd,
	// local stimuli
	input  wire logic                  ext_trig,
	input  wire logic                  button,
	input  wire logic                  matrix_mode,
	input  wire logic                  scan_running,
	// event conditions
	input  wire bstc_pkg::bstc_event_t evt,
	// output string in
	input  wire logic                  out_valid,
	input  wire logic [7:0]            out_data,
	input  wire logic                  out_last,
	output logic                       out_ready,
	// output string out
	output logic                       tx_valid,
	output logic [7:0]                 tx_data,
	input  wire logic                  tx_ready,
	// scan control
	output logic                       scan_start,
	output logic                       scan_stop,
	output logic                       cross_step,
	// status
	output logic [7:0]                 mask_ff,
	output logic [7:0]                 status_ff,
	output logic                       srq_ff,
	output logic [2:0]                 trig_mode_ff,
	output logic                       term_bad
);

	////////////////////////////////////////////////////////////////////////
	// submodules

	bstc_pkg::bstc_term_t term_ff;

	bstc_srq bstc_srq_i
	(
		.clk       (clk),
		.sys_rst   (sys_rst),
		.mask_wr   (mask_wr),
		.mask_data (mask_data),
		.evt       (evt),
		.spoll_rd  (spoll_rd),
		.mask_ff   (mask_ff),
		.status_ff (status_ff),
		.srq_ff    (srq_ff)
	);

	bstc_term bstc_term_i
	(
		.clk      (clk),
		.sys_rst  (sys_rst),
		.term_wr  (term_wr),
		.term_chr (term_chr),
		.dev_clr  (dev_clr),
		.term_ff  (term_ff),
		.term_bad (term_bad)
	);

	////////////////////////////////////////////////////////////////////////
	// trigger mode

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			trig_mode_ff <= bstc_pkg::TRG_RESET;
		else if (trig_mode_wr)
			trig_mode_ff <= trig_mode_data;
	end

	////////////////////////////////////////////////////////////////////////
	// talk hold and external edge

	logic talk_pend_ff;
	logic ext_ff;
	logic btn_ff;
	logic ext_edge;
	logic btn_edge;

	// pending talk for the one cycle after talk address
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			talk_pend_ff <= 1'b0;
		else if (data_req)
			talk_pend_ff <= 1'b0;
		else if (talk_addr)
			talk_pend_ff <= 1'b1;
		else
			talk_pend_ff <= 1'b0;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			ext_ff <= 1'b0;
			btn_ff <= 1'b0;
		end
		else
		begin
			ext_ff <= ext_trig;
			btn_ff <= button;
		end
	end

	assign ext_edge = ext_trig & ~ext_ff;
	assign btn_edge = button & ~btn_ff;

	////////////////////////////////////////////////////////////////////////
	// trigger decode

	logic talk_hit;
	logic trig_hit;
	logic want_start;
	logic want_stop;

	// talk counts only when no data request followed
	assign talk_hit = talk_pend_ff & ~data_req;

	always_comb
	begin
		case (trig_mode_ff)
			bstc_pkg::TRG_START_TALK, bstc_pkg::TRG_STOP_TALK: trig_hit = talk_hit;
			bstc_pkg::TRG_START_GET, bstc_pkg::TRG_STOP_GET:   trig_hit = group_trig;
			bstc_pkg::TRG_START_X, bstc_pkg::TRG_STOP_X:       trig_hit = exec_chr;
			bstc_pkg::TRG_START_EXT, bstc_pkg::TRG_STOP_EXT:   trig_hit = ext_edge;
			default:                                           trig_hit = 1'b0;
		endcase
	end

	// even codes start, odd codes stop
	assign want_start = trig_hit & ~trig_mode_ff[0];
	assign want_stop  = trig_hit & trig_mode_ff[0];

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			scan_start <= 1'b0;
			scan_stop  <= 1'b0;
			cross_step <= 1'b0;
		end
		else
		begin
			cross_step <= matrix_mode & trig_hit;
			// stop wins over a same-cycle start
			scan_start <= ~matrix_mode & ~want_stop & ((want_start & ~scan_running) | (btn_edge & ~scan_running));
			scan_stop  <= ~matrix_mode & ((want_stop | (btn_edge & scan_running)
				| (data_req & scan_running & trig_mode_ff == bstc_pkg::TRG_START_TALK)));
		end
	end

	////////////////////////////////////////////////////////////////////////
	// output string with terminator

	typedef enum logic [3:0] {
		BSTC_TX_DATA = 4'b0001,
		BSTC_TX_T1   = 4'b0010,
		BSTC_TX_T2   = 4'b0100,
		BSTC_TX_IDLE = 4'b1000
	} bstc_tx_state_t;

	bstc_tx_state_t tx_state_ff;
	bstc_tx_state_t nxt_tx_state;
	logic           tx_take;

	assign tx_take   = tx_valid & tx_ready;
	assign out_ready = (tx_state_ff == BSTC_TX_DATA) & (~tx_valid | tx_ready);

	always_comb
	begin
		nxt_tx_state = tx_state_ff;
		case (tx_state_ff)
			BSTC_TX_DATA:
			begin
				if (out_valid && out_ready && out_last && term_ff.kind != bstc_pkg::BSTC_TERM_NONE)
					nxt_tx_state = BSTC_TX_T1;
			end
			BSTC_TX_T1:
			begin
				if (tx_take)
					nxt_tx_state = (term_ff.kind == bstc_pkg::BSTC_TERM_TWO) ? BSTC_TX_T2 : BSTC_TX_IDLE;
			end
			BSTC_TX_T2:
			begin
				if (tx_take)
					nxt_tx_state = BSTC_TX_IDLE;
			end
			BSTC_TX_IDLE:
			begin
				if (tx_take)
					nxt_tx_state = BSTC_TX_DATA;
			end
			default:
				nxt_tx_state = BSTC_TX_DATA;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			tx_state_ff <= BSTC_TX_DATA;
		else
			tx_state_ff <= nxt_tx_state;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			tx_valid <= 1'b0;
			tx_data  <= 8'h00;
		end
		else if (out_valid && out_ready)
		begin
			tx_valid <= 1'b1;
			tx_data  <= out_data;
		end
		else if (tx_state_ff == BSTC_TX_T1 && (~tx_valid | tx_ready))
		begin
			tx_valid <= 1'b1;
			tx_data  <= term_ff.first;
		end
		else if (tx_state_ff == BSTC_TX_T2 && tx_take)
		begin
			tx_valid <= 1'b1;
			tx_data  <= term_ff.second;
		end
		else if (tx_take)
			tx_valid <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// checks

	sequence talk_then_req;
		talk_addr ##1 data_req;
	endsequence

	sequence last_taken;
		out_valid && out_ready && out_last && term_ff.kind != bstc_pkg::BSTC_TERM_NONE;
	endsequence

	AST_TALK_REQ_NO_START: assert property (@(posedge clk) disable iff (sys_rst)
		(talk_then_req ##0 (trig_mode_ff == bstc_pkg::TRG_START_TALK && !button && !btn_ff && !trig_mode_wr))
		|=> !scan_start)
		else $error("talk with data request started scan");
	AST_GET_START: assert property (@(posedge clk) disable iff (sys_rst)
		(group_trig && trig_mode_ff == 3'h2 && !matrix_mode && !scan_running) |=> scan_start)
		else $error("group trigger did not start");
	AST_X_STOP: assert property (@(posedge clk) disable iff (sys_rst)
		(exec_chr && trig_mode_ff == 3'h5 && !matrix_mode) |=> (scan_stop && !scan_start))
		else $error("execute character did not stop");
	AST_EXT_START: assert property (@(posedge clk) disable iff (sys_rst)
		(ext_trig && !ext_ff && trig_mode_ff == 3'h6 && !matrix_mode && !scan_running) |=> scan_start)
		else $error("external edge did not start");
	AST_MATRIX_STEP: assert property (@(posedge clk) disable iff (sys_rst)
		(matrix_mode && trig_hit) |=> (cross_step && !scan_start && !scan_stop))
		else $error("matrix trigger did not step once");
	AST_TALK_STOP: assert property (@(posedge clk) disable iff (sys_rst)
		(talk_pend_ff && !data_req && trig_mode_ff == 3'h1 && !matrix_mode) |=> scan_stop)
		else $error("talk did not stop");
	AST_GET_STOP: assert property (@(posedge clk) disable iff (sys_rst)
		(group_trig && trig_mode_ff == bstc_pkg::TRG_STOP_GET && !matrix_mode) |=> scan_stop)
		else $error("group trigger did not stop");
	AST_BTN_STOP: assert property (@(posedge clk) disable iff (sys_rst)
		(button && !btn_ff && scan_running && !matrix_mode) |=> scan_stop)
		else $error("button did not stop running scan");
	AST_REQ_STOP: assert property (@(posedge clk) disable iff (sys_rst)
		(data_req && scan_running && trig_mode_ff == bstc_pkg::TRG_START_TALK && !matrix_mode) |=> scan_stop)
		else $error("data request did not stop scan");
	AST_NO_START_STOP: assert property (@(posedge clk) disable iff (sys_rst)
		!(scan_start && scan_stop))
		else $error("start and stop in one cycle");
	AST_STEP_MATRIX_ONLY: assert property (@(posedge clk) disable iff (sys_rst)
		!matrix_mode |=> !cross_step)
		else $error("step outside matrix mode");
	AST_TERM_AFTER_LAST: assert property (@(posedge clk) disable iff (sys_rst)
		last_taken |=> (tx_state_ff == BSTC_TX_T1 && !out_ready))
		else $error("terminator did not follow last byte");
	AST_OUT_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
		(tx_valid && !tx_ready) |=> (tx_valid && $stable(tx_data)))
		else $error("output byte changed while stalled");
	AST_TX_ONEHOT: assert property (@(posedge clk) disable iff (sys_rst)
		$onehot(tx_state_ff))
		else $error("output state not one-hot");

endmodule
`default_nettype wire

// *** shared/bstc_pkg.sv ***
// Purpose: shared constants and types for the bus service-request, trigger and terminator control
// Assumes: one 50 MHz clock, synchronous active-high reset
// Notes: mask and status layouts, trigger modes, terminator codes
`default_nettype none
package bstc_pkg;

	// service-request enable mask field positions
	localparam int MSK_LOOP   = 5;
	localparam int MSK_SETTLE = 4;
	localparam int MSK_INTVL  = 3;
	localparam int MSK_SCAN   = 2;
	localparam int MSK_ALARM  = 1;
	localparam int MSK_ERR    = 0;
	localparam logic [7:0] MASK_RESET = 8'h00;
	localparam logic [7:0] MASK_MAX   = 8'h3f;

	// status byte field positions
	localparam int STB_RQS  = 6;
	localparam int STB_KIND = 5;
	localparam int DATA_SETTLE = 4;
	localparam int DATA_INTVL  = 3;
	localparam int DATA_SCAN   = 2;
	localparam int DATA_ALARM  = 1;
	localparam int ERR_LOOP    = 3;
	localparam int ERR_REMOTE  = 2;
	localparam int ERR_OPTION  = 1;
	localparam int ERR_CMD     = 0;

	// trigger mode codes
	localparam logic [2:0] TRG_START_TALK = 3'h0;
	localparam logic [2:0] TRG_STOP_TALK  = 3'h1;
	localparam logic [2:0] TRG_START_GET  = 3'h2;
	localparam logic [2:0] TRG_STOP_GET   = 3'h3;
	localparam logic [2:0] TRG_START_X    = 3'h4;
	localparam logic [2:0] TRG_STOP_X     = 3'h5;
	localparam logic [2:0] TRG_START_EXT  = 3'h6;
	localparam logic [2:0] TRG_STOP_EXT   = 3'h7;
	localparam logic [2:0] TRG_RESET      = 3'h0;

	// terminator characters
	localparam logic [7:0] CHR_CR  = 8'h0d;
	localparam logic [7:0] CHR_LF  = 8'h0a;
	localparam logic [7:0] CHR_DEL = 8'h7f;

	// terminator kinds
	typedef enum logic [1:0] {
		BSTC_TERM_NONE = 2'h0,
		BSTC_TERM_ONE  = 2'h1,
		BSTC_TERM_TWO  = 2'h2
	} bstc_term_kind_t;

	// programmed terminator
	typedef struct packed {
		bstc_term_kind_t kind;
		logic [7:0]      first;
		logic [7:0]      second;
	} bstc_term_t;

	localparam bstc_term_t TERM_RESET = '{kind: BSTC_TERM_TWO, first: 8'h0d, second: 8'h0a};

	// event condition group
	typedef struct packed {
		logic loop;
		logic settle;
		logic intvl;
		logic scan;
		logic alarm;
		logic remote;
		logic option;
		logic cmd;
	} bstc_event_t;

endpackage
`default_nettype wire

// *** design/bstc_srq.sv ***
// Purpose: service-request mask and status byte
// Assumes: event inputs are one-cycle pulses
// Notes: error events take precedence over data events in the byte
`timescale 1ns/1ps
`default_nettype none
module bstc_srq
(
	// clock and reset
	input  wire logic                 clk,
	input  wire logic                 sys_rst,
	// mask programming
	input  wire logic                 mask_wr,
	input  wire logic [7:0]           mask_data,
	// events and poll
	input  wire bstc_pkg::bstc_event_t evt,
	input  wire logic                 spoll_rd,
	// outputs
	output logic [7:0]                mask_ff,
	output logic [7:0]                status_ff,
	output logic                      srq_ff
);

	logic [7:0] nxt_status;
	logic       data_hit;
	logic       err_hit;

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			mask_ff <= bstc_pkg::MASK_RESET;
		else if (mask_wr)
			mask_ff <= mask_data & bstc_pkg::MASK_MAX;
	end

	assign err_hit  = (evt.loop & mask_ff[bstc_pkg::MSK_LOOP])
		| ((evt.remote | evt.option | evt.cmd) & mask_ff[bstc_pkg::MSK_ERR]);
	assign data_hit = (evt.settle & mask_ff[bstc_pkg::MSK_SETTLE])
		| (evt.intvl & mask_ff[bstc_pkg::MSK_INTVL])
		| (evt.scan & mask_ff[bstc_pkg::MSK_SCAN])
		| (evt.alarm & mask_ff[bstc_pkg::MSK_ALARM]);

	always_comb
	begin
		nxt_status = 8'h00;
		nxt_status[bstc_pkg::STB_RQS] = 1'b1;
		if (err_hit)
		begin
			nxt_status[bstc_pkg::STB_KIND]   = 1'b1;
			nxt_status[bstc_pkg::ERR_LOOP]   = evt.loop & mask_ff[bstc_pkg::MSK_LOOP];
			nxt_status[bstc_pkg::ERR_REMOTE] = evt.remote & mask_ff[bstc_pkg::MSK_ERR];
			nxt_status[bstc_pkg::ERR_OPTION] = evt.option & mask_ff[bstc_pkg::MSK_ERR];
			nxt_status[bstc_pkg::ERR_CMD]    = evt.cmd & mask_ff[bstc_pkg::MSK_ERR];
		end
		else
		begin
			nxt_status[bstc_pkg::DATA_SETTLE] = evt.settle & mask_ff[bstc_pkg::MSK_SETTLE];
			nxt_status[bstc_pkg::DATA_INTVL]  = evt.intvl & mask_ff[bstc_pkg::MSK_INTVL];
			nxt_status[bstc_pkg::DATA_SCAN]   = evt.scan & mask_ff[bstc_pkg::MSK_SCAN];
			nxt_status[bstc_pkg::DATA_ALARM]  = evt.alarm & mask_ff[bstc_pkg::MSK_ALARM];
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			status_ff <= 8'h00;
			srq_ff    <= 1'b0;
		end
		else if (err_hit | data_hit)
		begin
			status_ff <= nxt_status;
			srq_ff    <= 1'b1;
		end
		else if (spoll_rd)
		begin
			status_ff <= 8'h00;
			srq_ff    <= 1'b0;
		end
	end

	AST_NO_SRQ_UNMASKED: assert property (@(posedge clk) disable iff (sys_rst)
		(!srq_ff && !(err_hit | data_hit) && !spoll_rd) |=> !srq_ff)
		else $error("request raised without enabled event");
	AST_SRQ_ON_EVENT: assert property (@(posedge clk) disable iff (sys_rst)
		(err_hit | data_hit) |=> (srq_ff && status_ff[6]))
		else $error("enabled event did not raise request");
	AST_POLL_CLEARS: assert property (@(posedge clk) disable iff (sys_rst)
		(spoll_rd && !(err_hit | data_hit)) |=> (!srq_ff && status_ff == 8'h00))
		else $error("poll did not clear request");
	AST_ERR_KIND: assert property (@(posedge clk) disable iff (sys_rst)
		err_hit |=> (status_ff[5] && !status_ff[4] && !status_ff[7]))
		else $error("error byte layout wrong");
	AST_DATA_KIND: assert property (@(posedge clk) disable iff (sys_rst)
		(data_hit && !err_hit) |=> (!status_ff[5] && !status_ff[0] && !status_ff[7]))
		else $error("data byte layout wrong");
	AST_MASK_RANGE: assert property (@(posedge clk) disable iff (sys_rst)
		mask_wr |=> ((mask_ff == ($past(mask_data) & bstc_pkg::MASK_MAX)) && (mask_ff[7:6] == 2'h0)))
		else $error("mask not loaded");

endmodule
`default_nettype wire

// *** design/bstc_term.sv ***
// Purpose: programmable output terminator store
// Assumes: command decoder presents the character after the letter
// Notes: rejected characters leave the terminator unchanged
`timescale 1ns/1ps
`default_nettype none
module bstc_term
(
	// clock and reset
	input  wire logic                  clk,
	input  wire logic                  sys_rst,
	// programming
	input  wire logic                  term_wr,
	input  wire logic [7:0]            term_chr,
	input  wire logic                  dev_clr,
	// outputs
	output var bstc_pkg::bstc_term_t   term_ff,
	output logic                       term_bad
);

	function automatic logic chr_forbidden(input logic [7:0] c);
		chr_forbidden = (c >= 8'h41 && c <= 8'h5a) || (c >= 8'h30 && c <= 8'h39)
			|| c == 8'h20 || c == 8'h2b || c == 8'h2d || c == 8'h2f || c == 8'h28
			|| c == 8'h29 || c == 8'h2e || c == 8'h65 || c == 8'h3a;
	endfunction

	assign term_bad = term_wr && chr_forbidden(term_chr);

	always_ff @(posedge clk)
	begin
		if (sys_rst || dev_clr)
			term_ff <= bstc_pkg::TERM_RESET;
		else if (term_wr && !chr_forbidden(term_chr))
		begin
			case (term_chr)
				bstc_pkg::CHR_LF:
					term_ff <= '{kind: bstc_pkg::BSTC_TERM_TWO, first: bstc_pkg::CHR_CR, second: bstc_pkg::CHR_LF};
				bstc_pkg::CHR_CR:
					term_ff <= '{kind: bstc_pkg::BSTC_TERM_TWO, first: bstc_pkg::CHR_LF, second: bstc_pkg::CHR_CR};
				bstc_pkg::CHR_DEL:
					term_ff <= '{kind: bstc_pkg::BSTC_TERM_NONE, first: 8'h00, second: 8'h00};
				default:
					term_ff <= '{kind: bstc_pkg::BSTC_TERM_ONE, first: term_chr, second: 8'h00};
			endcase
		end
	end

	AST_CLR_DEFAULT: assert property (@(posedge clk) disable iff (sys_rst)
		dev_clr |=> (term_ff.kind == bstc_pkg::BSTC_TERM_TWO && term_ff.first == 8'h0d && term_ff.second == 8'h0a))
		else $error("device clear did not restore terminator");
	AST_DEL_NONE: assert property (@(posedge clk) disable iff (sys_rst)
		(term_wr && term_chr == 8'h7f && !dev_clr) |=> term_ff.kind == bstc_pkg::BSTC_TERM_NONE)
		else $error("delete did not select no terminator");
	AST_CR_SWAP: assert property (@(posedge clk) disable iff (sys_rst)
		(term_wr && term_chr == 8'h0d && !dev_clr) |=> (term_ff.first == 8'h0a && term_ff.second == 8'h0d))
		else $error("cr did not select lf cr");

endmodule
`default_nettype wire

// *** tb/bstc_host.sv ***
// Purpose: bus controller model, receives output bytes
// Assumes: slow stalls every other cycle
// Notes: bytes are kept in got for the bench
`timescale 1ns/1ps
`default_nettype none
module bstc_host
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       sys_rst,
	// byte stream
	input  wire logic       tx_valid,
	input  wire logic [7:0] tx_data,
	output logic            tx_ready,
	// pacing
	input  wire logic       slow
);
	logic [7:0] got[$];
	logic       ph_ff;
	//////////////////////////////////////////////////
	// pacing phase
	always_ff @(posedge clk)
	begin
		ph_ff <= sys_rst ? 1'b0 : ~ph_ff;
	end
	assign tx_ready = slow ? ph_ff : 1'b1;
	always @(posedge clk)
	begin
		if (tx_valid && tx_ready)
			got.push_back(tx_data);
	end
endmodule
`default_nettype wire

// *** tb/bstc_ctl_tb.sv ***
// Purpose: self-checking bench for bstc_ctl
// Assumes: 50 MHz clock, inputs driven 1 ns after edge
// Notes: host model collects output bytes
`timescale 1ns/1ps
`default_nettype none
module bstc_ctl_tb;
	logic clk = 0, sys_rst = 1, mask_wr = 0, trig_mode_wr = 0, term_wr = 0, dev_clr = 0;
	logic talk_addr = 0, data_req = 0, group_trig = 0, exec_chr = 0, spoll_rd = 0;
	logic ext_trig = 0, button = 0, matrix_mode = 0, scan_running = 0;
	logic out_valid = 0, out_last = 0, out_ready, tx_valid, tx_ready, slow = 0;
	logic scan_start, scan_stop, cross_step, srq_ff, term_bad;
	logic [7:0] mask_data = 0, term_chr = 0, out_data = 0, tx_data, mask_ff, status_ff;
	logic [2:0] trig_mode_data = 0, trig_mode_ff;
	bstc_pkg::bstc_event_t evt = '0;
	int fail_count = 0, checks = 0, n_st = 0, n_sp = 0, n_cs = 0;
	always #10 clk = ~clk;
	bstc_ctl bstc_ctl_i (.clk(clk), .sys_rst(sys_rst), .mask_wr(mask_wr), .mask_data(mask_data),
		.trig_mode_wr(trig_mode_wr), .trig_mode_data(trig_mode_data), .term_wr(term_wr),
		.term_chr(term_chr), .dev_clr(dev_clr), .talk_addr(talk_addr), .data_req(data_req),
		.group_trig(group_trig), .exec_chr(exec_chr), .spoll_rd(spoll_rd), .ext_trig(ext_trig),
		.button(button), .matrix_mode(matrix_mode), .scan_running(scan_running), .evt(evt),
		.out_valid(out_valid), .out_data(out_data), .out_last(out_last), .out_ready(out_ready),
		.tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .scan_start(scan_start),
		.scan_stop(scan_stop), .cross_step(cross_step), .mask_ff(mask_ff), .status_ff(status_ff),
		.srq_ff(srq_ff), .trig_mode_ff(trig_mode_ff), .term_bad(term_bad));
	bstc_host bstc_host_i (.clk(clk), .sys_rst(sys_rst), .tx_valid(tx_valid), .tx_data(tx_data),
		.tx_ready(tx_ready), .slow(slow));
	always @(posedge clk)
	begin
		n_st += (scan_start === 1'b1);
		n_sp += (scan_stop === 1'b1);
		n_cs += (cross_step === 1'b1);
	end
	//////////////////////////////////////////////////
	task automatic tick(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk(string n, logic [7:0] s, logic [7:0] e);
		checks++;
		if (s !== e)
		begin
			fail_count++;
			$display("[ERR] %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic wr_mask(logic [7:0] v);
		mask_wr = 1; mask_data = v; tick(1); mask_wr = 0; tick(1);
	endtask
	task automatic ev(logic [7:0] m, logic [7:0] v, logic [7:0] st);
		wr_mask(m); evt = v; tick(1); evt = '0;
		chk("status", status_ff, st);
		chk("srq", {7'h0, srq_ff}, {7'h0, st[6]});
		spoll_rd = 1; tick(1); spoll_rd = 0;
		chk("srq poll", {7'h0, srq_ff}, 8'h0);
	endtask
	task automatic wr_term(logic [7:0] c, logic bad);
		term_wr = 1; term_chr = c; #1;
		chk("term_bad", {7'h0, term_bad}, {7'h0, bad});
		tick(1); term_wr = 0; tick(1);
	endtask
	task automatic send_cmp(string n, logic [7:0] e[$]);
		out_valid = 1; out_data = 8'h41; out_last = 1;
		for (int k = 0; k < 50 && out_ready !== 1'b1; k++) tick(1);
		tick(1); out_valid = 0; out_last = 0; tick(12);
		chk(n, 8'(bstc_host_i.got.size()), 8'(e.size()));
		foreach (e[i]) if (i < bstc_host_i.got.size()) chk(n, bstc_host_i.got[i], e[i]);
		bstc_host_i.got.delete();
	endtask
	task automatic trig(int m, int s, logic mx, logic run, int st, int sp, int cs);
		trig_mode_wr = 1; trig_mode_data = 3'(m); tick(1); trig_mode_wr = 0;
		chk("mode", {5'h0, trig_mode_ff}, 8'(m));
		scan_running = run; matrix_mode = mx; n_st = 0; n_sp = 0; n_cs = 0;
		case (s)
			0, 5: talk_addr = 1;
			1: group_trig = 1;
			2: exec_chr = 1;
			3: ext_trig = 1;
			4: button = 1;
			default: ;
		endcase
		tick(1); talk_addr = 0; group_trig = 0; exec_chr = 0; data_req = (s == 5); tick(1); data_req = 0;
		tick(5); ext_trig = 0; button = 0;
		chk("start", 8'(n_st), 8'(st));
		chk("stop", 8'(n_sp), 8'(sp));
		chk("step", 8'(n_cs), 8'(cs));
		matrix_mode = 0;
	endtask
	//////////////////////////////////////////////////
	initial
	begin
		tick(20); sys_rst = 0; tick(1);
		chk("mask rst", mask_ff, bstc_pkg::MASK_RESET);
		chk("status rst", status_ff, 8'h0);
		chk("ready rst", {7'h0, out_ready}, 8'h1);
		$display("test reset done");
		wr_mask(8'hff); chk("mask", mask_ff, 8'h3f);
		ev(8'h04, 8'h10, 8'h44);
		ev(8'h3f, 8'h18, 8'h46);
		ev(8'h01, 8'h01, 8'h61);
		ev(8'h01, 8'h06, 8'h66);
		ev(8'h3f, 8'h90, 8'h68);
		ev(8'h20, 8'h80, 8'h68);
		ev(8'h3f, 8'h40, 8'h50);
		ev(8'h04, 8'h08, 8'h00);
		ev(8'h00, 8'hff, 8'h00);
		$display("test srq done");
		for (int m = 0; m < 8; m++) trig(m, m >> 1, 0, 1'(m % 2), 1 - m % 2, m % 2, 0);
		trig(0, 5, 0, 0, 0, 0, 0);
		trig(0, 5, 0, 1, 0, 1, 0);
		trig(2, 1, 1, 0, 0, 0, 1);
		trig(2, 4, 0, 0, 1, 0, 0);
		trig(3, 4, 0, 1, 0, 1, 0);
		$display("test trigger done");
		send_cmp("crlf", '{8'h41, 8'h0d, 8'h0a});
		wr_term(8'h0d, 0); slow = 1;
		send_cmp("lfcr", '{8'h41, 8'h0a, 8'h0d});
		wr_term(8'h0a, 0); slow = 0;
		send_cmp("lf", '{8'h41, 8'h0d, 8'h0a});
		wr_term(8'h7f, 0);
		send_cmp("none", '{8'h41});
		wr_term(8'h74, 0);
		wr_term(8'h41, 1);
		wr_term(8'h35, 1);
		send_cmp("single", '{8'h41, 8'h74});
		dev_clr = 1; tick(1); dev_clr = 0;
		send_cmp("clear", '{8'h41, 8'h0d, 8'h0a});
		$display("test terminator done");
		print_verdict();
	end
	initial
	begin
		repeat (20000) @(posedge clk);
		fail_count++;
		print_verdict();
	end
endmodule
`default_nettype wire
